//--- smbus_xfer_regs.vh
// Register offsets, field positions, reset values and timing for the
// two-wire transfer engine. Definitions only; included by bare name.
`ifndef SMBUS_XFER_REGS_VH
`define SMBUS_XFER_REGS_VH

// Register offsets on the special-function register bus
`define ADDR_DATA_BYTE 8'hc2
`define ADDR_CONTROL 8'hc0
`define ADDR_ACK_CFG 8'hbb

// Control register fields
`define CTL_MASTER 7
`define CTL_TXMODE 6
`define CTL_START 5
`define CTL_STOP 4
`define CTL_ACKNOWLEDGE_REQUEST_FLAG 3
`define CTL_ARBLOST 2
`define CTL_ACK 1
`define CTL_SI 0

// Acknowledge configuration field
`define CFG_HWACK 0

// Reset values
`define RST_DATA_BYTE 8'h00
`define RST_ACK_CFG 1'b0

// Bus timing: one quarter of a bus clock period
`define T_QUARTER_NS 2500
`define CLK_MHZ 100

// Bit phases inside one bus clock period
`define PH_0 2'h0
`define PH_1 2'h1
`define PH_2 2'h2
`define PH_3 2'h3

// Last bit index of a byte
`define LAST_BIT 3'h7

`endif

//--- byte_fifo.v
// Flip-flop FIFO with registered output word, valid and ready both sides.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk_sys_i,
    input wire reset_i,
    input wire [WIDTH-1:0] in_data_i,
    input wire in_valid_i,
    output reg in_ready_o,
    output reg [WIDTH-1:0] out_data_o,
    output reg out_valid_o,
    input wire out_ready_i
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wptr;
    reg [AW-1:0] rptr;
    reg [AW:0] count;
    wire push = in_valid_i & in_ready_o;
    wire pop = out_valid_o & out_ready_i;
    wire [AW-1:0] next_rptr = pop ? rptr + 1'b1 : rptr;
    wire [AW:0] next_count = count + {{AW{1'b0}}, push}
                             - {{AW{1'b0}}, pop};

    // Storage write
    always @(posedge clk_sys_i) begin
        if (push) begin
            mem[wptr] <= in_data_i;
        end
    end

    // Pointers, flags and the registered head word
    always @(posedge clk_sys_i) begin
        if (reset_i) begin
            wptr <= {AW{1'b0}};
            rptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
            in_ready_o <= 1'b1;
            out_valid_o <= 1'b0;
            out_data_o <= {WIDTH{1'b0}};
        end else begin
            if (push) begin
                wptr <= wptr + 1'b1;
            end
            rptr <= next_rptr;
            count <= next_count;
            in_ready_o <= (next_count != DEPTH[AW:0]);
            out_valid_o <= (next_count != {(AW+1){1'b0}});
            if (push && (wptr == next_rptr)) begin
                out_data_o <= in_data_i; // Bypass into empty head
            end else begin
                out_data_o <= mem[next_rptr];
            end
        end
    end
endmodule
`default_nettype wire

//--- smbus_master_transfer_engine.v
// Master transfer engine of a two-wire serial interface with its data,
// control and acknowledge configuration registers on the SFR bus.
// Assumes open-drain pins resolved outside; pins come from another domain.
`include "smbus_xfer_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module smbus_master_transfer_engine #(
    parameter QTR_CYCLES = (`T_QUARTER_NS * `CLK_MHZ) / 1000,
    parameter FIFO_DEPTH = 16,
    parameter FIFO_AW = 4
) (
    input wire clk_sys_i,
    input wire reset_i,
    input wire [7:0] sfr_addr_i,
    input wire sfr_wr_i,
    input wire sfr_rd_i,
    input wire [7:0] sfr_wdata_i,
    output reg [7:0] sfr_rdata_o,
    input wire scl_i,
    output reg scl_o,
    output reg scl_oe_o,
    input wire sda_i,
    output reg sda_o,
    output reg sda_oe_o,
    output reg si_o,
    output reg master_o,
    output reg txmode_o,
    output wire [7:0] rx_byte_o,
    output wire rx_valid_o,
    input wire rx_ready_i
);
    // One-hot engine states
    localparam [5:0] S_IDLE = 6'h01;
    localparam [5:0] S_START = 6'h02;
    localparam [5:0] S_BIT = 6'h04;
    localparam [5:0] S_ACK = 6'h08;
    localparam [5:0] S_HOLD = 6'h10;
    localparam [5:0] S_STOP = 6'h20;

    reg [5:0] state;
    reg [1:0] phase;
    reg [2:0] bitcnt;
    reg [15:0] qcnt;
    reg [7:0] serial_data_byte;
    reg start_request;
    reg stop_request;
    reg acknowledge_request_flag;
    reg ack_bit;
    reg hw_acknowledge_enable;
    reg dat_written;
    reg scl_m;
    reg scl_s;
    reg sda_m;
    reg sda_s;
    wire fifo_ready;
    wire qtick = (qcnt == 16'h0000);
    wire wr_data = sfr_wr_i && (sfr_addr_i == `ADDR_DATA_BYTE);
    wire wr_ctl = sfr_wr_i && (sfr_addr_i == `ADDR_CONTROL);
    wire wr_cfg = sfr_wr_i && (sfr_addr_i == `ADDR_ACK_CFG);
    wire byte_end = (state == S_BIT) && qtick && (phase == `PH_3)
                    && (bitcnt == `LAST_BIT);
    wire rx_push = byte_end && !txmode_o && fifo_ready;
    wire byte_stall = byte_end && !txmode_o && !fifo_ready;

    // Received bytes leave through a FIFO; a full FIFO stalls the bus
    byte_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_rx_fifo (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .in_data_i(serial_data_byte),
        .in_valid_i(rx_push),
        .in_ready_o(fifo_ready),
        .out_data_o(rx_byte_o),
        .out_valid_o(rx_valid_o),
        .out_ready_i(rx_ready_i)
    );

    // Two-stage synchronisers for the bus pins
    always @(posedge clk_sys_i) begin
        if (reset_i) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
        end else begin
            scl_m <= scl_i;
            scl_s <= scl_m;
            sda_m <= sda_i;
            sda_s <= sda_m;
        end
    end

    // Quarter-period tick generator
    always @(posedge clk_sys_i) begin
        if (reset_i || qtick) begin
            qcnt <= QTR_CYCLES[15:0] - 16'h0001;
        end else begin
            qcnt <= qcnt - 16'h0001;
        end
    end

    // Data register: CPU writes while byte-done, else MSB-first shifting
    always @(posedge clk_sys_i) begin
        if (reset_i) begin
            serial_data_byte <= `RST_DATA_BYTE;
        end else if (wr_data && si_o) begin
            serial_data_byte <= sfr_wdata_i;
        end else if (!si_o && (state == S_BIT) && qtick
                     && (phase == `PH_2) && scl_s) begin
            serial_data_byte <= {serial_data_byte[6:0], sda_s};
        end
    end

    // Configuration register
    always @(posedge clk_sys_i) begin
        if (reset_i) begin
            hw_acknowledge_enable <= `RST_ACK_CFG;
        end else if (wr_cfg) begin
            hw_acknowledge_enable <= sfr_wdata_i[`CFG_HWACK];
        end
    end

    // Register read port
    always @(posedge clk_sys_i) begin
        if (reset_i) begin
            sfr_rdata_o <= 8'h00;
        end else if (sfr_rd_i) begin
            case (sfr_addr_i)
                `ADDR_DATA_BYTE: sfr_rdata_o <= serial_data_byte;
                `ADDR_CONTROL: sfr_rdata_o <= {master_o, txmode_o,
                    start_request, stop_request, acknowledge_request_flag,
                    1'b0, ack_bit, si_o};
                `ADDR_ACK_CFG: sfr_rdata_o <= {7'h00, hw_acknowledge_enable};
                default: sfr_rdata_o <= 8'h00;
            endcase
        end
    end

    // Control bits and the transfer state machine
    always @(posedge clk_sys_i) begin
        if (reset_i) begin
            state <= S_IDLE;
            phase <= `PH_0;
            bitcnt <= 3'h0;
            si_o <= 1'b0;
            master_o <= 1'b0;
            txmode_o <= 1'b0;
            start_request <= 1'b0;
            stop_request <= 1'b0;
            acknowledge_request_flag <= 1'b0;
            ack_bit <= 1'b0;
            dat_written <= 1'b0;
            scl_o <= 1'b0;
            sda_o <= 1'b0;
            scl_oe_o <= 1'b0;
            sda_oe_o <= 1'b0;
        end else begin
            // Software side of the control register
            if (wr_ctl) begin
                start_request <= sfr_wdata_i[`CTL_START];
                stop_request <= sfr_wdata_i[`CTL_STOP];
                ack_bit <= sfr_wdata_i[`CTL_ACK];
                if (!sfr_wdata_i[`CTL_SI]) begin
                    si_o <= 1'b0;
                end
            end
            if (wr_data && si_o) begin
                dat_written <= 1'b1;
            end
            case (state)
                S_IDLE: begin
                    dat_written <= 1'b0;
                    scl_oe_o <= 1'b0;
                    sda_oe_o <= 1'b0;
                    phase <= `PH_0;
                    if (start_request && !si_o) begin
                        state <= S_START;
                    end
                end
                S_START: if (qtick) begin
                    case (phase)
                        `PH_0: begin
                            sda_oe_o <= 1'b0;
                            phase <= `PH_1;
                        end
                        `PH_1: begin
                            scl_oe_o <= 1'b0;
                            phase <= `PH_2;
                        end
                        `PH_2: if (scl_s) begin
                            sda_oe_o <= 1'b1; // START: data falls, clock high
                            phase <= `PH_3;
                        end
                        default: begin
                            scl_oe_o <= 1'b1;
                            phase <= `PH_0;
                            master_o <= 1'b1;
                            txmode_o <= 1'b1;
                            si_o <= 1'b1;
                            state <= S_HOLD;
                        end
                    endcase
                end
                S_BIT: if (qtick) begin
                    case (phase)
                        `PH_0: begin
                            // Transmit drives MSB; receive releases data
                            sda_oe_o <= txmode_o & ~serial_data_byte[7];
                            phase <= `PH_1;
                        end
                        `PH_1: begin
                            scl_oe_o <= 1'b0;
                            phase <= `PH_2;
                        end
                        `PH_2: if (scl_s) begin
                            phase <= `PH_3;
                        end
                        default: begin
                            scl_oe_o <= 1'b1;
                            if (bitcnt != `LAST_BIT) begin
                                bitcnt <= bitcnt + 3'h1;
                                phase <= `PH_0;
                            end else if (!byte_stall) begin
                                bitcnt <= 3'h0;
                                phase <= `PH_0;
                                if (txmode_o || hw_acknowledge_enable) begin
                                    state <= S_ACK;
                                end else begin
                                    acknowledge_request_flag <= 1'b1;
                                    si_o <= 1'b1;
                                    state <= S_HOLD;
                                end
                            end
                        end
                    endcase
                end
                S_ACK: if (qtick) begin
                    case (phase)
                        `PH_0: begin
                            sda_oe_o <= ~txmode_o & ack_bit;
                            phase <= `PH_1;
                        end
                        `PH_1: begin
                            scl_oe_o <= 1'b0;
                            phase <= `PH_2;
                        end
                        `PH_2: if (scl_s) begin
                            if (txmode_o) begin
                                ack_bit <= ~sda_s;
                            end
                            phase <= `PH_3;
                        end
                        default: begin
                            scl_oe_o <= 1'b1; // Data kept: no STOP as clock falls
                            phase <= `PH_0;
                            state <= S_HOLD;
                            if (txmode_o || hw_acknowledge_enable) begin
                                si_o <= 1'b1;
                            end
                        end
                    endcase
                end
                S_HOLD: begin
                    scl_oe_o <= 1'b1;
                    phase <= `PH_0;
                    if (!si_o && !wr_ctl) begin
                        if (acknowledge_request_flag) begin
                            acknowledge_request_flag <= 1'b0;
                            state <= S_ACK;
                        end else if (stop_request) begin
                            state <= S_STOP;
                        end else if (start_request) begin
                            state <= S_START;
                        end else begin
                            if (txmode_o && !dat_written) begin
                                txmode_o <= 1'b0;
                            end else if (!txmode_o && dat_written) begin
                                txmode_o <= 1'b1;
                            end
                            dat_written <= 1'b0; // Mode decided, forget the write
                            state <= S_BIT;
                        end
                    end
                end
                S_STOP: if (qtick) begin
                    case (phase)
                        `PH_0: begin
                            sda_oe_o <= 1'b1;
                            phase <= `PH_1;
                        end
                        `PH_1: begin
                            scl_oe_o <= 1'b0;
                            phase <= `PH_2;
                        end
                        `PH_2: if (scl_s) begin
                            sda_oe_o <= 1'b0; // STOP: data rises, clock high
                            phase <= `PH_3;
                        end
                        default: begin
                            phase <= `PH_0;
                            stop_request <= 1'b0;
                            master_o <= 1'b0;
                            txmode_o <= 1'b0;
                            state <= S_IDLE;
                        end
                    endcase
                end
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

//--- smbus_xfer_sva.sv
// Port checker for the two-wire master transfer engine.
// Assumes it is bound to the engine top; sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module smbus_xfer_sva (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic scl_oe_o,
    input wire logic sda_oe_o,
    input wire logic si_o,
    input wire logic master_o,
    input wire logic txmode_o,
    input wire logic [7:0] rx_byte_o,
    input wire logic rx_valid_o,
    input wire logic rx_ready_i
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    logic clr_si;
    logic unmapped;
    // Software clear of byte done, and reads outside the register map
    assign clr_si = sfr_wr_i && sfr_addr_i == 8'hc0 && !sfr_wdata_i[0];
    assign unmapped = sfr_addr_i != 8'hc0 && sfr_addr_i != 8'hc2
        && sfr_addr_i != 8'hbb;
    property p_scl_held; si_o |-> scl_oe_o; endproperty
    a_scl_held: assert property (p_scl_held)
        else $error("clock released while byte done is set");
    property p_si_stays; si_o && !clr_si |=> si_o; endproperty
    a_si_stays: assert property (p_si_stays)
        else $error("byte done dropped without a software clear");
    property p_si_clears; si_o && clr_si |=> !si_o; endproperty
    a_si_clears: assert property (p_si_clears)
        else $error("byte done not cleared by software");
    property p_enter_master; $rose(master_o) |-> si_o && txmode_o; endproperty
    a_enter_master: assert property (p_enter_master)
        else $error("master entry without transmit mode and byte done");
    property p_start_cond; $rose(sda_oe_o) && !master_o |-> !scl_oe_o;
    endproperty
    a_start_cond: assert property (p_start_cond)
        else $error("start pulled data while clock was low");
    property p_leave_master;
        $fell(master_o) |-> !scl_oe_o && !sda_oe_o && $past(!sda_oe_o, 1);
    endproperty
    a_leave_master: assert property (p_leave_master)
        else $error("master left without releasing both lines");
    property p_rdata_hold; !sfr_rd_i |=> $stable(sfr_rdata_o); endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data moved without a read");
    property p_unmapped; sfr_rd_i && unmapped |=> sfr_rdata_o == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read returned nonzero");
    property p_rx_hold;
        rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_byte_o);
    endproperty
    a_rx_hold: assert property (p_rx_hold)
        else $error("received byte lost while consumer stalled");
endmodule
bind smbus_master_transfer_engine smbus_xfer_sva smbus_xfer_sva_i (.*);
`default_nettype wire

//--- smbus_slave_model.sv
// Behavioural slave: stores written bytes, returns them on reads.
// Assumes resolved open-drain levels with pull-ups on both lines.
`timescale 1ns/1ps
`default_nettype none
module smbus_slave_model #(
    parameter logic [6:0] OWN_ADDR = 7'h2a
) (
    input wire logic scl_i,
    input wire logic sda_i,
    output var logic sda_pull_o,
    output var logic [7:0] wr_byte_o,
    output var int wr_count_o,
    output var logic m_ack_o
);
    logic [7:0] mem [0:15];
    logic [7:0] sh;
    logic [3:0] ptr;
    logic on = 1'b0;
    logic is_addr;
    logic rd;
    int bitn;
    initial begin
        sda_pull_o = 1'b0;
        wr_count_o = 0;
        m_ack_o = 1'b0;
    end
    // Start restarts the frame at address zero; stop ends it
    always @(negedge sda_i) begin
        if (scl_i === 1'b1) begin
            on = 1'b1;
            is_addr = 1'b1;
            rd = 1'b0;
            bitn = -1; // Clock fall after START is not a bit
            ptr = 4'h0;
        end
    end
    always @(posedge sda_i) begin
        if (scl_i === 1'b1) begin
            on = 1'b0;
            sda_pull_o = 1'b0;
        end
    end
    // Bits taken on the rising clock; ack slot holds the master answer
    always @(posedge scl_i) begin
        if (on && bitn < 8)
            sh = {sh[6:0], sda_i};
        else if (on)
            m_ack_o = !sda_i;
    end
    // Acknowledge and read data change only while the clock is low
    always @(negedge scl_i) begin
        if (on && bitn == 7) begin
            sda_pull_o = is_addr ? sh[7:1] == OWN_ADDR : !rd;
            if (is_addr)
                rd = sh[0];
            else if (!rd) begin
                wr_byte_o = sh;
                mem[ptr] = sh;
                ptr++;
                wr_count_o++;
            end
            bitn = 8;
        end else if (on && bitn == 8) begin
            on = is_addr || !rd || m_ack_o;
            if (rd && !is_addr)
                ptr++;
            sh = mem[ptr];
            sda_pull_o = on && rd && !sh[7];
            is_addr = 1'b0;
            bitn = 0;
        end else if (on) begin
            bitn++;
            sda_pull_o = rd && !is_addr && !sh[7];
        end
    end
endmodule
`default_nettype wire

//--- smbus_master_transfer_engine_tb.sv
// Bench: register tasks drive the engine, a slave model answers.
// Assumes a 100 MHz clock and four clocks per quarter bit (40 ns).
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, x, y) begin n_compared++; if ((y) !== (x)) begin \
    errors++; $display("Error %s expected %h seen %h", nm, x, y); end end
module smbus_master_transfer_engine_tb;
    localparam logic [6:0] SLV = 7'h2a;
    logic clk_sys_i = 1'b0, reset_i = 1'b1, sfr_wr_i = 1'b0;
    logic sfr_rd_i = 1'b0, rx_ready_i = 1'b0;
    logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00;
    wire logic [7:0] sfr_rdata_o, rx_byte_o, wr_byte;
    wire logic scl_o, scl_oe_o, sda_o, sda_oe_o, si_o, master_o, txmode_o;
    wire logic rx_valid_o, sda_pull, scl_w, sda_w, m_ack;
    int wr_count, last_wr = 0, errors = 0, n_compared = 0;
    logic [7:0] d [0:1];
    logic [7:0] e;
    logic [7:0] wq [$];
    logic [7:0] rq [$];
    // Open-drain lines with pull-ups
    assign scl_w = scl_oe_o ? scl_o : 1'b1;
    assign sda_w = (sda_oe_o ? sda_o : 1'b1) & !sda_pull;
    always #5 clk_sys_i = ~clk_sys_i;
    smbus_master_transfer_engine #(.QTR_CYCLES(4))
        smbus_master_transfer_engine_i (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i), .sfr_addr_i(sfr_addr_i),
        .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i),
        .sfr_rdata_o(sfr_rdata_o), .scl_i(scl_w), .scl_o(scl_o),
        .scl_oe_o(scl_oe_o), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe_o(sda_oe_o), .si_o(si_o), .master_o(master_o),
        .txmode_o(txmode_o), .rx_byte_o(rx_byte_o),
        .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i));
    smbus_slave_model #(.OWN_ADDR(SLV)) smbus_slave_model_i (
        .scl_i(scl_w), .sda_i(sda_w), .sda_pull_o(sda_pull),
        .wr_byte_o(wr_byte), .wr_count_o(wr_count), .m_ack_o(m_ack));
    task automatic stop_test();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys_i);
        sfr_addr_i <= a;
        sfr_wdata_i <= v;
        sfr_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        sfr_wr_i <= 1'b0;
    endtask
    // Register read, compared under a mask
    task automatic rdc(input logic [7:0] a, x, m);
        @(posedge clk_sys_i);
        sfr_addr_i <= a;
        sfr_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        sfr_rd_i <= 1'b0;
        #1;
        `CHK("register", x, sfr_rdata_o & m)
    endtask
    // Bounded wait for byte done (1) or for master mode to end (0)
    task automatic wait_on(input logic sel);
        int k;
        k = 0;
        #1; // Let the edge's register updates settle
        while ((sel ? si_o !== 1'b1 : master_o !== 1'b0) && k < 3000) begin
            @(posedge clk_sys_i);
            #1;
            k++;
        end
        if (k == 3000) begin
            errors++;
            $display("Error wait expected event seen timeout");
            stop_test();
        end
    endtask
    // Start, then address byte with direction bit
    task automatic open_frame(input logic dir);
        wr(8'hc0, 8'h20);
        wait_on(1);
        `CHK("mode", 2'b11, {master_o, txmode_o})
        wr(8'hc2, {SLV, dir});
        rdc(8'hc2, {SLV, dir}, 8'hff);
        wr(8'hc0, 8'h00);
        wait_on(1);
        rdc(8'hc0, 8'hc3, 8'hff);
    endtask
    task automatic end_frame(input logic [7:0] c);
        wr(8'hc0, c);
        wait_on(0);
        rdc(8'hc0, 8'h00, 8'hb9);
    endtask
    // Each byte appearing at either end is matched to the oldest note
    always @(posedge clk_sys_i) begin
        if (rx_valid_o === 1'b1 && rx_ready_i === 1'b1) begin
            e = rq.pop_front();
            `CHK("rx_byte", e, rx_byte_o)
        end
        if (wr_count != last_wr) begin
            last_wr = wr_count;
            e = wq.pop_front();
            `CHK("slave_byte", e, wr_byte)
        end
    end
    // Consumer of received bytes stalls at random
    always @(posedge clk_sys_i) rx_ready_i <= 1'($urandom_range(1));
    // Main sequence
    initial begin
        void'($urandom(56));
        repeat (10) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        rdc(8'hc2, 8'h00, 8'hff);
        rdc(8'hc0, 8'h00, 8'hff);
        rdc(8'h55, 8'h00, 8'hff);
        $display("test reset values done");
        d[0] = 8'($urandom);
        d[1] = 8'($urandom);
        open_frame(1'b0);
        for (int i = 0; i < 2; i++) begin
            wq.push_back(d[i]);
            wr(8'hc2, d[i]);
            wr(8'hc0, 8'h00);
            wait_on(1);
            rdc(8'hc0, 8'hc3, 8'hff);
        end
        end_frame(8'h10);
        $display("test master write done");
        rq.push_back(d[0]);
        rq.push_back(d[1]);
        open_frame(1'b1);
        wr(8'hc0, 8'h00);
        wait_on(1);
        rdc(8'hc0, 8'h89, 8'hfd);
        rdc(8'hc2, d[0], 8'hff);
        wr(8'hc0, 8'h02);
        wait_on(1);
        `CHK("ack", 1'b1, m_ack)
        rdc(8'hc2, d[1], 8'hff);
        end_frame(8'h10);
        `CHK("nack", 1'b0, m_ack)
        $display("test software acknowledge read done");
        wr(8'hbb, 8'h01);
        rdc(8'hbb, 8'h01, 8'h01);
        rq.push_back(d[0]);
        rq.push_back(d[1]);
        open_frame(1'b1);
        wr(8'hc0, 8'h02);
        wait_on(1);
        rdc(8'hc0, 8'h83, 8'hff);
        `CHK("ack", 1'b1, m_ack)
        rdc(8'hc2, d[0], 8'hff);
        wr(8'hc0, 8'h00);
        wait_on(1);
        `CHK("nack", 1'b0, m_ack)
        rdc(8'hc2, d[1], 8'hff);
        end_frame(8'h10);
        $display("test hardware acknowledge read done");
        repeat (40) @(posedge clk_sys_i);
        `CHK("notes_left", 0, rq.size() + wq.size())
        stop_test();
    end
endmodule
`default_nettype wire
